// [tx_synth_modulation_ctrl_bench.sv]
// self-checking bench for the host controller and synthesizer block
`timescale 1ns/1ps
`include "txsynth_regs.svh"
module tx_synth_modulation_ctrl_bench;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'b010;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [23:0] synth_word;
	logic [13:0] fsk_dev_out;
	logic [2:0] amp_bias;
	logic amp_on, low_noise_loop, gauss_on, gauss_bt_one, amp_path_drive, tx_bit;
	int failures = 0;
	int checked = 0;
	always #20 hclk = ~hclk;
	txsynth_if link();
	txsynth_host i_txsynth_host (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .link);
	txsynth_dev i_txsynth_dev (.hclk, .hresetn, .link, .synth_word, .fsk_dev_out, .amp_on,
		.amp_bias, .low_noise_loop, .gauss_on, .gauss_bt_one, .amp_path_drive, .tx_bit);
	txsynth_properties i_txsynth_properties (.hclk, .hresetn, .reg_wr(link.reg_wr),
		.reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
		.bit_clock_pin(link.bit_clock_pin), .synth_word, .amp_bias, .low_noise_loop,
		.gauss_on, .amp_path_drive);
	task automatic end_of_test();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic hwait();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			failures++;
			end_of_test();
		end
	endtask
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		hwait();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		hwait();
		q = hrdata;
	endtask
	task automatic dwr(input logic [6:0] a, input logic [7:0] d);
		logic [31:0] q;
		ahb(1'b1, `CTL_CMD, {8'h00, d, 6'h00, 2'b11, 1'b0, a}, q);
		repeat (4) @(posedge hclk);
	endtask
	task automatic drd(input logic [6:0] a, output logic [7:0] d);
		logic [31:0] q;
		ahb(1'b1, `CTL_CMD, {24'h00_0000, 1'b0, a}, q);
		repeat (3) @(posedge hclk);
		ahb(1'b0, `CTL_RDATA, 32'h0000_0000, q);
		d = q[7:0];
	endtask
	task automatic t_cal();
		logic [7:0] d;
		repeat (300) @(posedge hclk);
		drd(`DEV_OSC, d);
		chk(d[`OSC_CAL_COMPLETE], 1'b1);
		dwr(`DEV_OSC, 8'h08);
		drd(`DEV_OSC, d);
		chk(d[`OSC_CAL_COMPLETE], 1'b0);
		repeat (300) @(posedge hclk);
		drd(`DEV_OSC, d);
		chk(d[`OSC_CAL_COMPLETE], 1'b1);
	endtask
	task automatic t_freq();
		logic [7:0] d;
		logic [31:0] q;
		drd(`DEV_RATE_HIGH, d);
		chk(d, 8'h1A);
		chk(fsk_dev_out, `RST_DEV);
		dwr(`DEV_FRF_HIGH, 8'h12);
		dwr(`DEV_FRF_MID, 8'h34);
		chk(synth_word, `RST_FRF);
		dwr(`DEV_FRF_LOW, 8'h56);
		chk(synth_word, 24'h12_3456);
		dwr(`DEV_DEV_HIGH, 8'h0C);
		dwr(`DEV_DEV_LOW, 8'hCC);
		chk(fsk_dev_out, 14'h0CCC);
		ahb(1'b0, 32'h0000_0040, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		chk(hresp, 1'b0);
		dwr(`DEV_MODE, 8'h11);
		chk(low_noise_loop, 1'b1);
		dwr(`DEV_MODE, 8'h12);
		chk(low_noise_loop, 1'b0);
	endtask
	task automatic t_ook();
		logic [31:0] q;
		dwr(`DEV_SHAPING, 8'h20);
		dwr(`DEV_MODE, 8'h0D);
		ahb(1'b1, `CTL_PINS, 32'h0000_0003, q);
		repeat (20) @(posedge hclk);
		chk(amp_on, 1'b1);
		chk(amp_bias, `RAMP_MAX);
		chk(amp_path_drive, 1'b1);
		dwr(`DEV_MODE, 8'h8D);
		chk(amp_path_drive, 1'b0);
		dwr(`DEV_MODE, 8'h0D);
		ahb(1'b1, `CTL_PINS, 32'h0000_0001, q);
		repeat (20) @(posedge hclk);
		chk(amp_on, 1'b0);
		chk(amp_bias, 3'h0);
	endtask
	task automatic t_gauss();
		logic [31:0] q;
		int n;
		dwr(`DEV_RATE_HIGH, 8'h01);
		dwr(`DEV_RATE_LOW, 8'h00);
		dwr(`DEV_RATE_FRAC, 8'h08);
		dwr(`DEV_MODE, 8'h00);
		ahb(1'b1, `CTL_TXBITS, 32'hA5A5_A5A5, q);
		dwr(`DEV_MODE, 8'h09);
		chk(gauss_on, 1'b1);
		chk(gauss_bt_one, 1'b1);
		for (int i = 0; i < 8; i++) begin
			n = 0;
			while (link.bit_clock_pin !== 1'b1 && n < 600) begin
				@(negedge hclk);
				n++;
			end
			if (n >= 600) begin
				failures++;
				end_of_test();
			end
			if (i > 0) chk(n + 128, (i % 2) ? 256 : 257);
			repeat (128) @(negedge hclk);
			chk(tx_bit, (32'hA5A5_A5A5 >> (31 - i)) & 32'h0000_0001);
		end
	endtask
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_cal();
		t_freq();
		t_ook();
		t_gauss();
		end_of_test();
	end
endmodule

// [txsynth_dev.sv]
// synthesizer, rc calibration, bit rate and modulator control
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "txsynth_regs.svh"
module txsynth_dev (
	input wire logic hclk,
	input wire logic hresetn,
	txsynth_if.device link,
	output logic [23:0] synth_word,
	output logic [13:0] fsk_dev_out,
	output logic amp_on,
	output logic [2:0] amp_bias,
	output logic low_noise_loop,
	output logic gauss_on,
	output logic gauss_bt_one,
	output logic amp_path_drive,
	output logic tx_bit
);
	logic [7:0] frf_hi_r, frf_mid_r, rate_hi_r, rate_lo_r, dev_hi_r, dev_lo_r;
	logic [7:0] mode_r, shape_r, frac_r;
	logic cal_trig_r, cal_done_r;
	logic [15:0] cal_cnt_r;
	txsynth_pkg::cal_state_t cal_st_r;
	logic [23:0] synth_r;
	logic [19:0] acc_r;
	logic bclk_r, bit_r, on_r;
	logic [2:0] bias_r;
	logic [7:0] rdata_r;
	logic txd_s1, txd_s2;
	wire wr = link.reg_wr;
	wire [6:0] a = link.reg_addr;
	wire [7:0] d = link.reg_wdata;
	wire tx_mode = mode_r[`MODE_TX] & ~mode_r[`MODE_RX];
	wire ook = mode_r[`MODE_OOK];
	wire cont = mode_r[`MODE_CONT];
	wire [1:0] shape = shape_r[`SHAPE_LSB+1:`SHAPE_LSB];
	wire gauss = ~ook & (shape != 2'b00);
	wire [3:0] frac_eff = ook ? 4'h0 : frac_r[3:0];
	wire [19:0] period = {rate_hi_r, rate_lo_r, frac_eff};
	wire rate_run = tx_mode & (~cont | gauss);
	wire acc_wrap = rate_run & (acc_r + 20'h0_0010 >= period);
	wire bit_src = (cont & ~gauss) ? txd_s2 : bit_r;
	wire [7:0] status_v = {5'h00, cal_st_r == txsynth_pkg::D_CAL, bclk_r, cal_done_r};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frf_hi_r <= 8'h00;
			frf_mid_r <= 8'h00;
			synth_r <= `RST_FRF;
			rate_hi_r <= 8'(`RST_RATE >> 8);
			rate_lo_r <= 8'(`RST_RATE);
			dev_hi_r <= {2'b00, 6'(`RST_DEV >> 8)};
			dev_lo_r <= 8'(`RST_DEV);
			mode_r <= 8'h00;
			shape_r <= 8'h00;
			frac_r <= 8'h00;
		end else if (wr) begin
			if (a == `DEV_FRF_HIGH) frf_hi_r <= d;
			if (a == `DEV_FRF_MID) frf_mid_r <= d;
			if (a == `DEV_FRF_LOW) synth_r <= {frf_hi_r, frf_mid_r, d};
			if (a == `DEV_RATE_HIGH) rate_hi_r <= d;
			if (a == `DEV_RATE_LOW) rate_lo_r <= d;
			if (a == `DEV_DEV_HIGH) dev_hi_r <= {2'b00, d[5:0]};
			if (a == `DEV_DEV_LOW) dev_lo_r <= d;
			if (a == `DEV_MODE) mode_r <= d;
			if (a == `DEV_SHAPING) shape_r <= d;
			if (a == `DEV_RATE_FRAC) frac_r <= {4'h0, d[3:0]};
		end
	end
	// calibration: runs at reset release and on host trigger
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cal_st_r <= txsynth_pkg::D_CAL;
			cal_cnt_r <= 16'h0000;
			cal_done_r <= 1'b0;
			cal_trig_r <= 1'b0;
		end else begin
			cal_trig_r <= wr & (a == `DEV_OSC) & d[`OSC_CAL_TRIGGER];
			unique case (cal_st_r)
				txsynth_pkg::D_IDLE, txsynth_pkg::D_DONE: begin
					if (cal_trig_r) begin
						cal_st_r <= txsynth_pkg::D_CAL;
						cal_done_r <= 1'b0;
						cal_cnt_r <= 16'h0000;
					end
				end
				txsynth_pkg::D_CAL: begin
					cal_cnt_r <= cal_cnt_r + 16'h0001;
					if (cal_cnt_r == `RC_CAL_CYCLES - 16'h0001) begin
						cal_st_r <= txsynth_pkg::D_DONE;
						cal_done_r <= 1'b1;
					end
				end
				default: cal_st_r <= txsynth_pkg::D_IDLE;
			endcase
		end
	end
	// bit timing: accumulate 16 per clock against the 16x period
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_r <= 20'h0_0000;
			bclk_r <= 1'b0;
			bit_r <= 1'b0;
			txd_s1 <= 1'b0;
			txd_s2 <= 1'b0;
		end else begin
			txd_s1 <= link.tx_data_pin;
			txd_s2 <= txd_s1;
			if (!rate_run) acc_r <= 20'h0_0000;
			else if (acc_wrap) acc_r <= acc_r + 20'h0_0010 - period;
			else acc_r <= acc_r + 20'h0_0010;
			bclk_r <= acc_wrap & cont & gauss;
			if (acc_wrap & cont & gauss) bit_r <= txd_s2;
		end
	end
	// amplifier keying and bias ramp
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			on_r <= 1'b0;
			bias_r <= 3'h0;
			rdata_r <= 8'h00;
		end else begin
			on_r <= tx_mode & (ook ? bit_src : 1'b1);
			if (!(ook & (shape != 2'b00))) bias_r <= on_r ? `RAMP_MAX : 3'h0;
			else if (on_r && bias_r != `RAMP_MAX) bias_r <= bias_r + 3'h1;
			else if (!on_r && bias_r != 3'h0) bias_r <= bias_r - 3'h1;
			unique case (a)
				`DEV_FRF_HIGH: rdata_r <= frf_hi_r;
				`DEV_FRF_MID: rdata_r <= frf_mid_r;
				`DEV_FRF_LOW: rdata_r <= synth_r[7:0];
				`DEV_RATE_HIGH: rdata_r <= rate_hi_r;
				`DEV_RATE_LOW: rdata_r <= rate_lo_r;
				`DEV_DEV_HIGH: rdata_r <= dev_hi_r;
				`DEV_DEV_LOW: rdata_r <= dev_lo_r;
				`DEV_MODE: rdata_r <= mode_r;
				`DEV_SHAPING: rdata_r <= shape_r;
				`DEV_RATE_FRAC: rdata_r <= frac_r;
				`DEV_OSC: rdata_r <= {3'h0, cal_done_r, 4'h0};
				`DEV_STATUS: rdata_r <= status_v;
				default: rdata_r <= 8'h00;
			endcase
		end
	end
	assign link.reg_rdata = rdata_r;
	assign link.bit_clock_pin = bclk_r;
	assign synth_word = synth_r;
	assign fsk_dev_out = {dev_hi_r[5:0], dev_lo_r};
	assign amp_on = on_r;
	assign amp_bias = bias_r;
	assign low_noise_loop = mode_r[`MODE_LOW_NOISE] & tx_mode;
	assign gauss_on = gauss;
	assign gauss_bt_one = shape == 2'b01;
	assign amp_path_drive = ~mode_r[`MODE_AMP_PATH] & link.tx_amp_enable_pin;
	assign tx_bit = bit_src;
endmodule

// [txsynth_host.sv]
// host controller: ahb-lite registers drive device writes and transmit data
`timescale 1ns/1ps
`include "txsynth_regs.svh"
module txsynth_host (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	txsynth_if.host link
);
	logic ph_wr_r;
	logic [31:0] ph_addr_r;
	logic [31:0] hrdata_r;
	logic [15:0] cmd_r;
	logic [7:0] rd_r;
	logic [31:0] bits_r;
	logic [5:0] nbits_r;
	logic tx_amp_enable_pin_r, txd_r;
	logic wr_r;
	logic [6:0] addr_r;
	logic [7:0] wd_r;
	logic bc_s1, bc_s2, bc_d;
	wire take = hsel & htrans[1] & hready;
	wire bc_rise = bc_s2 & ~bc_d;
	wire w_cmd = ph_wr_r & (ph_addr_r[7:0] == `CTL_CMD);
	wire w_bits = ph_wr_r & (ph_addr_r[7:0] == `CTL_TXBITS);
	wire w_pins = ph_wr_r & (ph_addr_r[7:0] == `CTL_PINS);
	wire [31:0] rd_v = (haddr[7:0] == `CTL_CMD) ? {16'h0000, cmd_r} :
		(haddr[7:0] == `CTL_RDATA) ? {24'h00_0000, rd_r} :
		(haddr[7:0] == `CTL_STATUS) ? {26'h000_0000, nbits_r} :
		(haddr[7:0] == `CTL_TXBITS) ? bits_r :
		(haddr[7:0] == `CTL_PINS) ? {30'h0000_0000, txd_r, tx_amp_enable_pin_r} : 32'h0000_0000;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_wr_r <= 1'b0;
			ph_addr_r <= 32'h0000_0000;
			hrdata_r <= 32'h0000_0000;
		end else begin
			ph_wr_r <= take & hwrite;
			ph_addr_r <= haddr;
			if (take & ~hwrite) hrdata_r <= rd_v;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_r <= 16'h0000;
			rd_r <= 8'h00;
			wr_r <= 1'b0;
			addr_r <= 7'h00;
			wd_r <= 8'h00;
			tx_amp_enable_pin_r <= 1'b0;
			bits_r <= 32'h0000_0000;
			nbits_r <= 6'h00;
			txd_r <= 1'b0;
			bc_s1 <= 1'b0;
			bc_s2 <= 1'b0;
			bc_d <= 1'b0;
		end else begin
			bc_s1 <= link.bit_clock_pin;
			bc_s2 <= bc_s1;
			bc_d <= bc_s2;
			wr_r <= w_cmd & hwdata[`CMD_GO] & hwdata[`CMD_WRITE];
			if (w_cmd) begin
				cmd_r <= hwdata[15:0];
				addr_r <= hwdata[6:0];
				wd_r <= hwdata[23:16];
			end
			rd_r <= link.reg_rdata;
			if (w_pins) tx_amp_enable_pin_r <= hwdata[0];
			if (w_bits) begin
				bits_r <= hwdata;
				nbits_r <= 6'h20;
				txd_r <= hwdata[31];
			end else if (bc_rise && nbits_r != 6'h00) begin
				bits_r <= {bits_r[30:0], 1'b0};
				txd_r <= bits_r[30];
				nbits_r <= nbits_r - 6'h01;
			end else if (w_pins) txd_r <= hwdata[1];
		end
	end
	assign hrdata = hrdata_r;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign link.reg_wr = wr_r;
	assign link.reg_addr = addr_r;
	assign link.reg_wdata = wd_r;
	assign link.tx_data_pin = txd_r;
	assign link.tx_amp_enable_pin = tx_amp_enable_pin_r;
endmodule

// [txsynth_if.sv]
// link between the host controller and the synthesizer block
`timescale 1ns/1ps
interface txsynth_if;
	logic reg_wr;
	logic [6:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic tx_data_pin;
	logic bit_clock_pin;
	logic tx_amp_enable_pin;
	modport device(input reg_wr, input reg_addr, input reg_wdata, output reg_rdata,
		input tx_data_pin, output bit_clock_pin, input tx_amp_enable_pin);
	modport host(output reg_wr, output reg_addr, output reg_wdata, input reg_rdata,
		output tx_data_pin, input bit_clock_pin, output tx_amp_enable_pin);
endinterface

// [txsynth_pkg.sv]
// types for both ends; only txsynth_dev uses them
package txsynth_pkg;
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_SHIFT = 2'b01,
		H_DONE = 2'b10
	} host_state_t;
	typedef enum logic [1:0] {
		D_IDLE = 2'b00,
		D_CAL = 2'b01,
		D_DONE = 2'b10
	} cal_state_t;
endpackage

// [txsynth_properties.sv]
// concurrent checks on the link and the device outputs
`timescale 1ns/1ps
`include "txsynth_regs.svh"
module txsynth_properties (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic reg_wr,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic bit_clock_pin,
	input wire logic [23:0] synth_word,
	input wire logic [2:0] amp_bias,
	input wire logic low_noise_loop,
	input wire logic gauss_on,
	input wire logic amp_path_drive
);
	logic [7:0] hi_r;
	logic [7:0] mid_r;
	logic [7:0] mode_r;
	logic [7:0] shape_r;
	wire logic ook_shape;
	assign ook_shape = mode_r[`MODE_OOK] && (shape_r[6:5] != 2'b00);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hi_r <= 8'h00;
			mid_r <= 8'h00;
			mode_r <= 8'h00;
			shape_r <= 8'h00;
		end else if (reg_wr) begin
			if (reg_addr == `DEV_FRF_HIGH) hi_r <= reg_wdata;
			if (reg_addr == `DEV_FRF_MID) mid_r <= reg_wdata;
			if (reg_addr == `DEV_MODE) mode_r <= reg_wdata;
			if (reg_addr == `DEV_SHAPING) shape_r <= reg_wdata;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_low_write;
		reg_wr && reg_addr == `DEV_FRF_LOW;
	endsequence
	sequence s_upper_write;
		reg_wr && reg_addr != `DEV_FRF_LOW;
	endsequence
	property p_apply;
		s_low_write |=> synth_word == {hi_r, mid_r, $past(reg_wdata)};
	endproperty
	property p_hold;
		s_upper_write |=> $stable(synth_word);
	endproperty
	property p_wr_pulse;
		$rose(reg_wr) |=> !reg_wr;
	endproperty
	property p_clk_pulse;
		bit_clock_pin |=> !bit_clock_pin;
	endproperty
	property p_rx_loop;
		mode_r[`MODE_RX] && $stable(mode_r) |-> !low_noise_loop;
	endproperty
	property p_path;
		mode_r[`MODE_AMP_PATH] && $stable(mode_r) |-> !amp_path_drive;
	endproperty
	property p_gauss;
		mode_r[`MODE_OOK] && $stable(mode_r) |-> !gauss_on;
	endproperty
	property p_ramp;
		ook_shape && $past(ook_shape) |-> amp_bias == $past(amp_bias)
			|| amp_bias == $past(amp_bias) + 3'h1 || amp_bias == $past(amp_bias) - 3'h1;
	endproperty
	a_apply: assert property (p_apply) else $error("carrier word not applied");
	a_hold: assert property (p_hold) else $error("carrier moved on upper write");
	a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
	a_clk_pulse: assert property (p_clk_pulse) else $error("bit clock too long");
	a_rx_loop: assert property (p_rx_loop) else $error("low noise loop in receive");
	a_path: assert property (p_path) else $error("path driven when select one");
	a_gauss: assert property (p_gauss) else $error("gaussian on in ook");
	a_ramp: assert property (p_ramp) else $error("bias jumped");
endmodule

// [txsynth_regs.svh]
// register offsets, fields, reset values and timing constants for the synthesizer control block
`ifndef TXSYNTH_REGS_SVH
`define TXSYNTH_REGS_SVH
// device register addresses on the device interface
`define DEV_FRF_HIGH 7'h06
`define DEV_FRF_MID 7'h07
`define DEV_FRF_LOW 7'h08
`define DEV_RATE_HIGH 7'h02
`define DEV_RATE_LOW 7'h03
`define DEV_DEV_HIGH 7'h04
`define DEV_DEV_LOW 7'h05
`define DEV_OSC 7'h0A
`define DEV_SHAPING 7'h0B
`define DEV_MODE 7'h01
`define DEV_RATE_FRAC 7'h0C
`define DEV_STATUS 7'h0D
// osc register fields
`define OSC_CAL_TRIGGER 3
`define OSC_CAL_COMPLETE 4
// mode register fields
`define MODE_TX 0
`define MODE_RX 1
`define MODE_OOK 2
`define MODE_CONT 3
`define MODE_LOW_NOISE 4
`define MODE_AMP_PATH 7
// shaping register field: 2 bits at [6:5]
`define SHAPE_LSB 5
// reset values
`define RST_FRF 24'h00_0000
`define RST_RATE 16'h1A0B
`define RST_DEV 14'h0052
// rc calibration duration in clocks
`define RC_CAL_CYCLES 16'h0100
// ook bias ramp: 8 levels, 0 to 7, one level per step
`define RAMP_MAX 3'h7
// controller register byte addresses (ahb)
`define CTL_CMD 32'h0000_0000
`define CTL_WDATA 32'h0000_0004
`define CTL_RDATA 32'h0000_0008
`define CTL_STATUS 32'h0000_000C
`define CTL_TXBITS 32'h0000_0010
`define CTL_PINS 32'h0000_0014
// cmd fields
`define CMD_GO 8
`define CMD_WRITE 9
// link bit clock divider in host clocks (half period)
`define LINK_HALF 4'h4
`endif
